// [pkg/mas_map.svh]
/*
 * register indices, field positions, reset values and temperature figures of
 * the alarm status and scan select block.
 * assumes: byte address of a register is four times its index.
 */
// Operation
// - alarm bit sets after N consecutive out-of-range samples
// - in-range sample before N keeps bit clear
// - latched mode: bit holds until read after condition
// - latched bit cleared only by read or resets; bit 2 also cleared when local sensor disabled
// - in latched mode a status read clears all; persisting conditions reassert
// - hold-off mode: bit follows condition, no read needed
// - reserved status bits 15, 1, 0 read zero
// - bits 14..11 flag inputs 0..3 out of range
// - bits 10, 9 flag local temperature, when enabled
// - bits 8..5 flag remote temperatures, when enabled
// - bits 4, 3 flag remote sensor faults
// - bit 2 die overheat at 150 C, 8 C hysteresis
// - scan selected inputs from bit 14 down to 0
// - single-ended result stored in own data register
// - pair 0/1 result stored in channel 0 register
// - pair 2/3 result stored in channel 2 register
// - pair 0/1 only with pattern 001 on 14..12
// - pair 2/3 only with pattern 001 on 11..9
// - bits 8..0 select channels 4 to 12
// - alarm enables gate only the alarm pin
// - channel count code maps to 1..256, default 16
// - scan continues with second select register 14..12
`ifndef MAS_MAP_SVH
`define MAS_MAP_SVH

`define MAS_IDX_STATUS 8'h4F
`define MAS_IDX_CHSEL0 8'h50
`define MAS_IDX_CHSEL1 8'h51
`define MAS_IDX_ALMCTL 8'h4E
`define MAS_IDX_CONFIG 8'h4C
`define MAS_IDX_DATA0 8'h23

`define MAS_RST_STATUS 16'h0000
`define MAS_RST_CHSEL 16'h0000
`define MAS_RST_ALMCTL 16'h0000
`define MAS_RST_CONFIG 16'h0070

`define MAS_STATUS_MASK 16'h7FFC
`define MAS_CHSEL0_MASK 16'h7FFF
`define MAS_CHSEL1_MASK 16'h7000
`define MAS_ALMCTL_MASK 16'h7FFC
`define MAS_CONFIG_MASK 16'h00FF

`define MAS_BIT_HOLD_OFF 2
`define MAS_FLD_CHCNT_HI 7
`define MAS_FLD_CHCNT_LO 5
`define MAS_FLD_TCNT_HI 4
`define MAS_FLD_TCNT_LO 3
`define MAS_BIT_LOCAL_ON 0
`define MAS_BIT_REMOTE_A_ON 1
`define MAS_BIT_REMOTE_B_ON 2
`define MAS_BIT_OVERHEAT 2

`define MAS_OVERHEAT_SET_C 150
`define MAS_OVERHEAT_HYST_C 8

`endif

// [pkg/mas_pkg.sv]
/*
 * types of the alarm status and scan select block.
 * assumes: constants come from mas_map.svh.
 */
package mas_pkg;

    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_ISSUE = 3'b010,
        SCAN_WAIT = 3'b100
    } mas_scan_t;

    typedef logic [8:0] mas_count_t;

endpackage : mas_pkg

// [logic/mas_top.sv]
/*
 * alarm status flags with consecutive-sample filtering, scan channel
 * selection sequencer and result storage, behind an axi4-lite slave.
 * assumes: an external converter takes one request at a time and returns
 * one result with its threshold verdict; temperature sensors deliver
 * per-sample verdicts; all inputs are synchronous to aclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mas_map.svh"

module mas_top #(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic conv_valid,
    input wire logic conv_ready,
    output logic [3:0] conv_chan,
    output logic conv_diff,
    input wire logic res_valid,
    input wire logic [11:0] res_data,
    input wire logic res_out_of_range,
    input wire logic [2:0] temp_valid,
    input wire logic [2:0] temp_under,
    input wire logic [2:0] temp_over,
    input wire logic [1:0] remote_fault,
    input wire logic signed [9:0] die_temp,
    output logic alarm_n
);

    localparam int NSRC = 12;
    localparam int NSLOT = 18;
    localparam logic signed [9:0] OVERHEAT_SET = 10'(`MAS_OVERHEAT_SET_C);
    localparam logic signed [9:0] OVERHEAT_CLR =
        10'(`MAS_OVERHEAT_SET_C - `MAS_OVERHEAT_HYST_C);

    if (ADDR_W < 10) begin : g_addr_w_check
        $error("mas_top: ADDR_W must be at least 10");
    end

    // ==================================================================
    // register bus
    // ==================================================================
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_idx_q, aw_idx_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] status_q, status_d;
    logic [15:0] chsel0_q, chsel0_d, chsel1_q, chsel1_d;
    logic [15:0] almctl_q, almctl_d, config_q, config_d;
    logic [11:0] data_q [16];
    logic [11:0] data_d [16];
    logic wr_go, rd_go, rd_status;
    logic [7:0] ar_idx;
    logic [15:0] wr_val;

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign ar_idx = s_axi_araddr[9:2];
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign rd_status = rd_go && (ar_idx == `MAS_IDX_STATUS);

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
        merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge

    always_comb begin
        aw_have_d = aw_have_q;
        aw_idx_d = aw_idx_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        chsel0_d = chsel0_q;
        chsel1_d = chsel1_q;
        almctl_d = almctl_q;
        config_d = config_q;
        wr_val = 16'h0000;
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_idx_d = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            case (aw_idx_q)
                `MAS_IDX_CHSEL0: begin
                    wr_val = merge(chsel0_q, wdata_q, wstrb_q);
                    chsel0_d = wr_val & `MAS_CHSEL0_MASK;
                end
                `MAS_IDX_CHSEL1: begin
                    wr_val = merge(chsel1_q, wdata_q, wstrb_q);
                    chsel1_d = wr_val & `MAS_CHSEL1_MASK;
                end
                `MAS_IDX_ALMCTL: begin
                    wr_val = merge(almctl_q, wdata_q, wstrb_q);
                    almctl_d = wr_val & `MAS_ALMCTL_MASK;
                end
                `MAS_IDX_CONFIG: begin
                    wr_val = merge(config_q, wdata_q, wstrb_q);
                    config_d = wr_val & `MAS_CONFIG_MASK;
                end
                // status and data are read-only: write accepted, no effect
                `MAS_IDX_STATUS: bresp_d = 2'h0;
                default: begin
                    if (aw_idx_q < `MAS_IDX_DATA0 ||
                        aw_idx_q > `MAS_IDX_DATA0 + 8'h0F) begin
                        bresp_d = 2'h2;
                    end
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            rdata_d = 32'h0000_0000;
            case (ar_idx)
                `MAS_IDX_STATUS: rdata_d = {16'h0000, status_q};
                `MAS_IDX_CHSEL0: rdata_d = {16'h0000, chsel0_q};
                `MAS_IDX_CHSEL1: rdata_d = {16'h0000, chsel1_q};
                `MAS_IDX_ALMCTL: rdata_d = {16'h0000, almctl_q};
                `MAS_IDX_CONFIG: rdata_d = {16'h0000, config_q};
                default: begin
                    if (ar_idx >= `MAS_IDX_DATA0 &&
                        ar_idx <= `MAS_IDX_DATA0 + 8'h0F) begin
                        rdata_d = {20'h00000,
                                   data_q[4'(ar_idx - `MAS_IDX_DATA0)]};
                    end else begin
                        rresp_d = 2'h2;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // scan sequencer
    // ==================================================================
    mas_pkg::mas_scan_t scan_q, scan_d;
    logic [4:0] ptr_q, ptr_d;
    logic [3:0] cur_chan_q, cur_chan_d;
    logic cur_diff_q, cur_diff_d;
    logic [NSLOT-1:0] sel;
    logic pair01, pair23;

    // slot 17 is select bit 14 of the first register, slot 0 bit 12 of
    // the second one
    function automatic logic [4:0] slot_map(input logic [4:0] s);
        case (s)
            5'h11: slot_map = 5'h00;
            5'h10: slot_map = 5'h01;
            5'h0F: slot_map = 5'h10;
            5'h0E: slot_map = 5'h02;
            5'h0D: slot_map = 5'h03;
            5'h0C: slot_map = 5'h12;
            5'h02: slot_map = 5'h0D;
            5'h01: slot_map = 5'h0E;
            5'h00: slot_map = 5'h0F;
            default: slot_map = 5'(5'h0F - s);
        endcase
    endfunction : slot_map

    assign pair01 = chsel0_q[12] && chsel0_q[14:13] == 2'h0;
    assign pair23 = chsel0_q[9] && chsel0_q[11:10] == 2'h0;
    assign sel = {chsel0_q[14:13], pair01, chsel0_q[11:10], pair23,
                  chsel0_q[8:0], chsel1_q[14:12]};
    assign conv_valid = (scan_q == mas_pkg::SCAN_ISSUE) && sel[ptr_q];
    assign conv_chan = cur_chan_q;
    assign conv_diff = cur_diff_q;

    always_comb begin
        scan_d = scan_q;
        ptr_d = ptr_q;
        for (int k = 0; k < 16; k++) begin
            data_d[k] = data_q[k];
        end
        case (scan_q)
            mas_pkg::SCAN_IDLE: begin
                ptr_d = 5'(NSLOT - 1);
                if (|sel) begin
                    scan_d = mas_pkg::SCAN_ISSUE;
                end
            end
            mas_pkg::SCAN_ISSUE: begin
                if (!(|sel)) begin
                    scan_d = mas_pkg::SCAN_IDLE;
                end else if (!sel[ptr_q]) begin
                    ptr_d = (ptr_q == 5'h00) ? 5'(NSLOT - 1) : ptr_q - 5'h01;
                end else if (conv_ready) begin
                    scan_d = mas_pkg::SCAN_WAIT;
                end
            end
            mas_pkg::SCAN_WAIT: begin
                if (res_valid) begin
                    data_d[cur_chan_q] = res_data;
                    ptr_d = (ptr_q == 5'h00) ? 5'(NSLOT - 1) : ptr_q - 5'h01;
                    scan_d = mas_pkg::SCAN_ISSUE;
                end
            end
            default: scan_d = mas_pkg::SCAN_IDLE;
        endcase
        {cur_diff_d, cur_chan_d} = slot_map(ptr_d);
    end

    // ==================================================================
    // alarm filtering and status
    // ==================================================================
    mas_pkg::mas_count_t cnt_q [NSRC];
    mas_pkg::mas_count_t cnt_d [NSRC];
    mas_pkg::mas_count_t n_ch, n_temp, n_i;
    logic [NSRC-1:0] samp, oor, en, hit, active;
    logic hold_off, local_on, ra_on, rb_on, ch_done;
    logic heat_q, heat_d;

    assign hold_off = almctl_q[`MAS_BIT_HOLD_OFF];
    assign local_on = config_q[`MAS_BIT_LOCAL_ON];
    assign ra_on = config_q[`MAS_BIT_REMOTE_A_ON];
    assign rb_on = config_q[`MAS_BIT_REMOTE_B_ON];
    assign ch_done = (scan_q == mas_pkg::SCAN_WAIT) && res_valid;
    assign n_ch = 9'h001 << ((config_q[`MAS_FLD_CHCNT_HI:`MAS_FLD_CHCNT_LO]
                  == 3'h0) ? 4'h0 : 4'(config_q[7:5]) + 4'h1);
    assign n_temp = 9'h001 << config_q[`MAS_FLD_TCNT_HI:`MAS_FLD_TCNT_LO];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            samp[i] = ch_done && cur_chan_q == 4'(i);
            oor[i] = res_out_of_range;
            en[i] = 1'b1;
        end
        samp[11:4] = {temp_valid[2], temp_valid[1], temp_valid[2],
                      temp_valid[2], temp_valid[1], temp_valid[1],
                      temp_valid[0], temp_valid[0]};
        oor[11:4] = {remote_fault[1], remote_fault[0], temp_over[2],
                     temp_under[2], temp_over[1], temp_under[1],
                     temp_over[0], temp_under[0]};
        en[11:4] = {rb_on, ra_on, rb_on, rb_on, ra_on, ra_on,
                    local_on, local_on};
        for (int i = 0; i < NSRC; i++) begin
            n_i = (i < 4) ? n_ch : n_temp;
            cnt_d[i] = cnt_q[i];
            hit[i] = 1'b0;
            if (!en[i]) begin
                cnt_d[i] = 9'h000;
            end else if (samp[i] && oor[i]) begin
                if (cnt_q[i] < n_i) begin
                    cnt_d[i] = cnt_q[i] + 9'h001;
                end
                hit[i] = (cnt_q[i] + 9'h001 >= n_i);
            end else if (samp[i]) begin
                cnt_d[i] = 9'h000;
            end
            active[i] = en[i] && cnt_d[i] >= n_i;
        end
    end

    always_comb begin
        heat_d = heat_q;
        if (!local_on) begin
            heat_d = 1'b0;
        end else if (temp_valid[0] && die_temp >= OVERHEAT_SET) begin
            heat_d = 1'b1;
        end else if (temp_valid[0] && die_temp <= OVERHEAT_CLR) begin
            heat_d = 1'b0;
        end
        status_d = status_q;
        for (int i = 0; i < NSRC; i++) begin
            if (hold_off) begin
                status_d[14-i] = active[i];
            end else begin
                // read clears all, a same-cycle hit still sets
                status_d[14-i] = (status_q[14-i] && !rd_status) ||
                                 hit[i];
            end
        end
        if (hold_off || !local_on) begin
            status_d[`MAS_BIT_OVERHEAT] = heat_d;
        end else begin
            status_d[`MAS_BIT_OVERHEAT] = (status_q[2] && !rd_status) ||
                (temp_valid[0] && heat_d);
        end
        status_d = status_d & `MAS_STATUS_MASK;
    end

    // thermal alarm cannot be masked; the rest only gate the pin
    assign alarm_n = !(|(status_q & (almctl_q | 16'h0004)));

    // ==================================================================
    // registers
    // ==================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_idx_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            status_q <= `MAS_RST_STATUS;
            chsel0_q <= `MAS_RST_CHSEL;
            chsel1_q <= `MAS_RST_CHSEL;
            almctl_q <= `MAS_RST_ALMCTL;
            config_q <= `MAS_RST_CONFIG;
            scan_q <= mas_pkg::SCAN_IDLE;
            ptr_q <= 5'h11;
            cur_chan_q <= 4'h0;
            cur_diff_q <= 1'b0;
            heat_q <= 1'b0;
            for (int k = 0; k < 16; k++) begin
                data_q[k] <= 12'h000;
            end
            for (int i = 0; i < NSRC; i++) begin
                cnt_q[i] <= 9'h000;
            end
        end else begin
            aw_have_q <= aw_have_d;
            aw_idx_q <= aw_idx_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            status_q <= status_d;
            chsel0_q <= chsel0_d;
            chsel1_q <= chsel1_d;
            almctl_q <= almctl_d;
            config_q <= config_d;
            scan_q <= scan_d;
            ptr_q <= ptr_d;
            cur_chan_q <= cur_chan_d;
            cur_diff_q <= cur_diff_d;
            heat_q <= heat_d;
            for (int k = 0; k < 16; k++) begin
                data_q[k] <= data_d[k];
            end
            for (int i = 0; i < NSRC; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

endmodule : mas_top
`default_nettype wire

// [testbench/mas_top_monitor.sv]
/*
 * checker for the alarm status and scan select block, bound to mas_top.
 * assumes: only top-level ports are visible; register map from mas_map.svh.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mas_map.svh"

module mas_top_monitor #(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic conv_valid,
    input wire logic conv_ready,
    input wire logic [3:0] conv_chan,
    input wire logic conv_diff,
    input wire logic res_valid
);
    // ==========================================================
    // read index tracking
    logic [7:0] ridx_q;
    logic [7:0] ridx_d;
    logic mapped;

    always_comb begin
        ridx_d = ridx_q;
        if (s_axi_arvalid && s_axi_arready) begin
            ridx_d = 8'(s_axi_araddr >> 2);
        end
    end

    always_ff @(posedge aclk) begin
        ridx_q <= aresetn ? ridx_d : 8'h00;
    end

    assign mapped = (ridx_q == `MAS_IDX_STATUS) ||
        (ridx_q == `MAS_IDX_CHSEL0) || (ridx_q == `MAS_IDX_CHSEL1) ||
        (ridx_q == `MAS_IDX_ALMCTL) || (ridx_q == `MAS_IDX_CONFIG) ||
        (ridx_q >= 8'h23 && ridx_q <= 8'h32);

    // ==========================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_status_rsvd_zero: assert property (
        s_axi_rvalid && ridx_q == `MAS_IDX_STATUS
        |-> s_axi_rdata[31:15] == 17'h00000 && s_axi_rdata[1:0] == 2'h0)
        else $error("status reserved bits not zero");
    a_chsel_rsvd_zero: assert property (
        s_axi_rvalid && ridx_q == `MAS_IDX_CHSEL0
        |-> s_axi_rdata[31:15] == 17'h00000)
        else $error("channel select bit 15 not zero");
    a_unmapped_err: assert property (
        s_axi_rvalid && !mapped
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_req_hold: assert property (
        conv_valid && !conv_ready
        |=> conv_valid && $stable(conv_chan) && $stable(conv_diff))
        else $error("conversion request changed before taken");
    a_pair_chan: assert property (
        conv_valid && conv_diff |-> conv_chan inside {4'h0, 4'h2})
        else $error("pair request on wrong channel");
    a_take_wait: assert property (
        conv_valid && conv_ready |=> !conv_valid)
        else $error("new request before result");
    a_result_gap: assert property (
        res_valid |-> !conv_valid)
        else $error("request while result pending");
endmodule : mas_top_monitor

bind mas_top mas_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

`default_nettype wire

// [testbench/mas_top_bench.sv]
/*
 * self-checking bench for the alarm status and scan select block.
 * assumes: bench stands in for bus master, converter and temperature sensors.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mas_map.svh"

module mas_top_bench;
    logic aclk, aresetn;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, conv_chan;
    logic [1:0] s_axi_bresp, s_axi_rresp, remote_fault;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, conv_valid, conv_ready, conv_diff;
    logic res_valid, res_out_of_range, alarm_n;
    logic [11:0] res_data;
    logic [2:0] temp_valid, temp_under, temp_over;
    logic signed [9:0] die_temp;
    int error_cnt, checks_done;

    mas_top dut (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // shared tasks
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 300) begin
            error_cnt++;
            $display("Error at %0t: wait timed out", $time);
            wrap_up();
        end
    endtask : step

    task do_reset;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    task wr(input logic [7:0] idx, input logic [15:0] d);
        int n;
        logic a, w;
        n = 0;
        a = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(a && w)) begin
            step(n);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                a = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        while (!s_axi_bvalid) step(n);
        chk(32'(s_axi_bresp), 32'h00000000);
    endtask : wr

    task rd(input logic [7:0] idx, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        step(n);
        while (!s_axi_arready) step(n);
        s_axi_arvalid <= 1'b0;
        step(n);
        while (!s_axi_rvalid) step(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd

    task st(input logic [15:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(`MAS_IDX_STATUS, d, r);
        chk(d, {16'h0000, e});
    endtask : st

    task conv_one(input logic [3:0] ch, input logic df,
                  input logic [11:0] v, input logic o);
        int n;
        n = 0;
        step(n);
        while (!conv_valid) step(n);
        chk(32'({conv_diff, conv_chan}), 32'({df, ch}));
        conv_ready <= 1'b1;
        step(n);
        conv_ready <= 1'b0;
        res_valid <= 1'b1;
        res_data <= v;
        res_out_of_range <= o;
        step(n);
        res_valid <= 1'b0;
    endtask : conv_one

    task tsample(input logic [2:0] v, input logic [2:0] u,
                 input logic [2:0] o, input logic [1:0] f,
                 input logic signed [9:0] t);
        temp_valid <= v;
        temp_under <= u;
        temp_over <= o;
        remote_fault <= f;
        die_temp <= t;
        @(posedge aclk);
        temp_valid <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask : tsample

    // ==========================================================
    // scenarios
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        do_reset();
        st(16'h0000);
        rd(`MAS_IDX_CONFIG, d, r);
        chk(d, 32'h00000070);
        wr(`MAS_IDX_STATUS, 16'hFFFF);
        st(16'h0000);
        wr(`MAS_IDX_CHSEL0, 16'hFFFF);
        rd(`MAS_IDX_CHSEL0, d, r);
        chk(d, 32'h00007FFF);
        rd(8'hFF, d, r);
        chk({30'h00000000, r}, 32'h00000002);
    endtask : t_regs

    task scan_run(input logic [15:0] s0, input logic [15:0] s1,
                  input int cnt, input logic [34:0] seq);
        int i;
        logic [4:0] e;
        logic [31:0] d;
        logic [1:0] r;
        do_reset();
        wr(`MAS_IDX_CHSEL0, s0);
        wr(`MAS_IDX_CHSEL1, s1);
        for (i = 0; i < cnt; i++) begin
            e = seq[i*5 +: 5];
            conv_one(e[3:0], e[4], 12'h9A0 + 12'(i), 1'b0);
        end
        rd(8'h23 + {4'h0, e[3:0]}, d, r);
        chk(d, {20'h00000, 12'h9A0 + 12'(cnt - 1)});
    endtask : scan_run

    task t_count;
        int i;
        do_reset();
        wr(`MAS_IDX_CHSEL0, 16'h4000);
        for (i = 0; i < 31; i++) begin
            conv_one(4'h0, 1'b0, 12'h000, i != 15);
        end
        st(16'h0000);
        conv_one(4'h0, 1'b0, 12'h000, 1'b1);
        conv_one(4'h0, 1'b0, 12'h000, 1'b0);
        st(16'h4000);
        st(16'h0000);
        wr(`MAS_IDX_ALMCTL, 16'h0004);
        wr(`MAS_IDX_CONFIG, 16'h0030);
        for (i = 0; i < 4; i++) begin
            conv_one(4'h0, 1'b0, 12'h000, 1'b1);
        end
        repeat (2) @(posedge aclk);
        chk({31'h00000000, alarm_n}, 32'h00000001);
        wr(`MAS_IDX_ALMCTL, 16'h4004);
        chk({31'h00000000, alarm_n}, 32'h00000000);
        conv_one(4'h0, 1'b0, 12'h000, 1'b0);
        repeat (2) @(posedge aclk);
        chk({31'h00000000, alarm_n}, 32'h00000001);
        st(16'h0000);
    endtask : t_count

    task t_temp;
        int i;
        logic signed [9:0] t [6];
        logic [5:0] hi;
        t = '{10'sd149, 10'sd150, 10'sd145, 10'sd143, 10'sd142, 10'sd150};
        hi = 6'h11;
        do_reset();
        wr(`MAS_IDX_CONFIG, 16'h0061);
        tsample(3'h3, 3'h2, 3'h1, 2'h1, 10'sd20);
        st(16'h0200);
        wr(`MAS_IDX_CONFIG, 16'h0067);
        tsample(3'h7, 3'h3, 3'h4, 2'h3, 10'sd20);
        st(16'h0538);
        tsample(3'h7, 3'h3, 3'h4, 2'h3, 10'sd20);
        do_reset();
        st(16'h0000);
        wr(`MAS_IDX_CONFIG, 16'h0061);
        wr(`MAS_IDX_ALMCTL, 16'h0004);
        for (i = 0; i < 6; i++) begin
            tsample(3'h1, 3'h0, 3'h0, 2'h0, t[i]);
            chk({31'h00000000, alarm_n}, {31'h00000000, hi[i]});
        end
        wr(`MAS_IDX_CONFIG, 16'h0060);
        repeat (2) @(posedge aclk);
        chk({31'h00000000, alarm_n}, 32'h00000001);
    endtask : t_temp

    // ==========================================================
    // main sequence
    initial begin
        error_cnt = 0;
        checks_done = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 10'h000;
        s_axi_araddr = 10'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        conv_ready = 1'b0;
        res_valid = 1'b0;
        res_data = 12'h000;
        res_out_of_range = 1'b0;
        temp_valid = 3'h0;
        temp_under = 3'h0;
        temp_over = 3'h0;
        remote_fault = 2'h0;
        die_temp = 10'sd0;
        t_regs();
        scan_run(16'h6A41, 16'h4000, 7, {5'h00, 5'h0D, 5'h0C, 5'h06,
            5'h02, 5'h01, 5'h00});
        scan_run(16'h1200, 16'h0000, 3, {20'h00000, 5'h10, 5'h12,
            5'h10});
        scan_run(16'h5600, 16'h0000, 3, {20'h00000, 5'h00, 5'h03,
            5'h00});
        t_count();
        t_temp();
        wrap_up();
    end
endmodule : mas_top_bench

`default_nettype wire
